// File: design/fpes_core.v
// Floating-point error signalling core with aliased register stack
// How it works
// RULE1 - Report bit set: take internal vector 10h
// RULE2 - Report bit clear: outside logic raises interrupt
// RULE3 - Unmasked float exception drives error output low
// RULE4 - Error low, ignore negated: stall, await interrupt
// RULE5 - Outside logic routes error to interrupt controller
// RULE6 - Outside logic asserts ignore on port write
// RULE7 - Ignore sampled asserted: drop error, resume
// RULE8 - Outside logic negates ignore when error clears
// RULE9 - Packed-integer instructions raise no float exceptions
// RULE10 - Pending error reported at next sensitive boundary
// RULE11 - Ignore only counts when sensitive and report clear; in ST_FROZE and ST_SERV the core honours it on any cycle
// RULE12 - Packed registers alias the float stack
// RULE13 - No new exception vectors are added
// RULE14 - Outside ignore latch cleared by system reset
`timescale 1ns/10ps
`include "fpes_map.vh"
module fpes_core #(
   parameter NUM_REGS  = `FPES_NUM_REGS,
   parameter WIDTH     = `FPES_REG_WIDTH,
   parameter IDX_WIDTH = `FPES_IDX_WIDTH
) (
   input  wire                 CLK_IN,
   input  wire                 RST_IN,
   input  wire                 NUMERIC_FAULT_REPORT_SEL_IN,
   input  wire                 IGNORE_NUMERIC_FAULT_IN_N,
   input  wire                 BOUNDARY_IN,
   input  wire [1:0]           INSTR_CLASS_IN,
   input  wire                 FP_EXC_IN,
   input  wire                 INT_ACK_IN,
   input  wire                 REG_WR_IN,
   input  wire [IDX_WIDTH-1:0] REG_WR_IDX_IN,
   input  wire [WIDTH-1:0]     REG_WR_DATA_IN,
   input  wire [IDX_WIDTH-1:0] REG_RD_IDX_IN,
   output reg                  FP_ERROR_OUT_N,
   output reg                  STALL_OUT,
   output reg                  VEC_TAKE_OUT,
   output reg  [7:0]           VEC_NUM_OUT,
   output reg                  PENDING_OUT,
   output wire [WIDTH-1:0]     REG_RD_DATA_OUT
);
   // Sequencer states, one-hot
   localparam [2:0] ST_RUN   = 3'b001;   // Executing normally
   localparam [2:0] ST_FROZE = 3'b010;   // Stalled, waiting for interrupt
   localparam [2:0] ST_SERV  = 3'b100;   // In service routine, error shown

   reg [2:0] state;         // Current state
   reg [2:0] next_state;    // Next state
   reg       pending;       // Unmasked exception awaiting report
   reg       next_pending;
   reg       next_err_n;
   reg       next_stall;
   reg       next_vec;

   wire sens    = BOUNDARY_IN && is_sensitive(INSTR_CLASS_IN);
   wire ignore  = !IGNORE_NUMERIC_FAULT_IN_N;
   // Only float instructions can raise an exception
   wire raise   = FP_EXC_IN && INSTR_CLASS_IN == `FPES_CLS_FP;   // RULE9

   // Float, packed-integer and wait are error-sensitive classes
   function is_sensitive;
      input [1:0] cls;
      begin
         is_sensitive = (cls != `FPES_CLS_OTHER);
      end
   endfunction

   // Next-state and output decode
   always @* begin
      next_state   = state;
      next_pending = pending | raise;                  // RULE3
      next_err_n   = FP_ERROR_OUT_N;
      next_stall   = STALL_OUT;
      next_vec     = 1'b0;
      case (state)
         ST_RUN: begin
            if (pending && sens) begin                 // RULE10
               if (NUMERIC_FAULT_REPORT_SEL_IN) begin
                  // Internal vector, no pins involved
                  next_vec     = 1'b1;                 // RULE1 RULE13
                  next_pending = raise;
               end else if (ignore) begin
                  // Ignore honoured here only with report clear, and also in ST_FROZE and ST_SERV
                  next_pending = raise;                // RULE7 RULE11
               end else begin
                  next_err_n = 1'b0;                   // RULE3
                  next_stall = 1'b1;                   // RULE4
                  next_state = ST_FROZE;
               end
            end
         end
         ST_FROZE: begin
            if (ignore) begin
               // Drop the exception and resume
               next_pending = raise;                   // RULE7
               next_err_n   = 1'b1;
               next_stall   = 1'b0;
               next_state   = ST_RUN;
            end else if (INT_ACK_IN) begin
               // Outside interrupt taken; run the service routine
               next_stall = 1'b0;                      // RULE4
               next_state = ST_SERV;
            end
         end
         ST_SERV: begin
            if (ignore) begin
               // Port write asserted ignore; clear the error
               next_pending = raise;                   // RULE7
               next_err_n   = 1'b1;
               next_state   = ST_RUN;
            end else if (sens) begin
               // Sensitive instruction in handler stalls again
               next_stall = 1'b1;                      // RULE4
               next_state = ST_FROZE;
            end
         end
         default: begin
            next_state = ST_RUN;
            next_err_n = `FPES_RST_ERR_N;
            next_stall = `FPES_RST_STALL;
         end
      endcase
   end

   // State and output registers
   always @(posedge CLK_IN) begin
      if (RST_IN) begin
         state          <= ST_RUN;
         pending        <= 1'b0;
         FP_ERROR_OUT_N <= `FPES_RST_ERR_N;
         STALL_OUT      <= `FPES_RST_STALL;
         VEC_TAKE_OUT   <= 1'b0;
         VEC_NUM_OUT    <= 8'h00;
         PENDING_OUT    <= 1'b0;
      end else begin
         state          <= next_state;
         pending        <= next_pending;
         FP_ERROR_OUT_N <= next_err_n;
         STALL_OUT      <= next_stall;
         VEC_TAKE_OUT   <= next_vec;
         VEC_NUM_OUT    <= next_vec ? `FPES_VEC_NUMERIC : 8'h00;   // RULE1
         PENDING_OUT    <= next_pending;
      end
   end

   // Shared store for float and packed-integer views
   fpes_regstack #(
      .NUM_REGS  (NUM_REGS),
      .WIDTH     (WIDTH),
      .IDX_WIDTH (IDX_WIDTH)
   ) u_stack (
      .clk     (CLK_IN),
      .rst     (RST_IN),
      .wr_en   (REG_WR_IN),
      .wr_idx  (REG_WR_IDX_IN),
      .wr_data (REG_WR_DATA_IN),
      .rd_idx  (REG_RD_IDX_IN),
      .rd_data (REG_RD_DATA_OUT)
   );   // RULE12
endmodule // fpes_core

// File: design/fpes_map.vh
// Constants for the floating-point error signalling block
`ifndef FPES_MAP_VH
`define FPES_MAP_VH
// Internal vector used when errors are reported in-core
`define FPES_VEC_NUMERIC    8'h10
// Device-not-available vector (shared save/restore of aliased state)
`define FPES_VEC_DEV_NA     8'h07
// Instruction class codes
`define FPES_CLS_OTHER      2'h0
`define FPES_CLS_FP         2'h1
`define FPES_CLS_PKD        2'h2
`define FPES_CLS_WAIT       2'h3
// Aliased register file shape
`define FPES_NUM_REGS       8
`define FPES_REG_WIDTH      64
`define FPES_IDX_WIDTH      3
// Reset values
`define FPES_RST_ERR_N      1'b1
`define FPES_RST_STALL      1'b0
`endif

// File: design/fpes_regstack.v
// Eight-entry register stack shared by float and packed-integer views
`timescale 1ns/10ps
`include "fpes_map.vh"
module fpes_regstack #(
   parameter NUM_REGS  = `FPES_NUM_REGS,
   parameter WIDTH     = `FPES_REG_WIDTH,
   parameter IDX_WIDTH = `FPES_IDX_WIDTH
) (
   input  wire                 clk,
   input  wire                 rst,
   input  wire                 wr_en,
   input  wire [IDX_WIDTH-1:0] wr_idx,
   input  wire [WIDTH-1:0]     wr_data,
   input  wire [IDX_WIDTH-1:0] rd_idx,
   output reg  [WIDTH-1:0]     rd_data
);
   reg [WIDTH-1:0] mem [0:NUM_REGS-1];   // One store, both views
   genvar g;

   // Each entry written by index, cleared at reset
   generate
      for (g = 0; g < NUM_REGS; g = g + 1) begin : g_ent
         always @(posedge clk) begin
            if (rst) begin
               mem[g] <= {WIDTH{1'b0}};
            end else if (wr_en && wr_idx == g) begin
               mem[g] <= wr_data;
            end
         end
      end
   endgenerate

   // Registered read port
   always @(posedge clk) begin
      if (rst) begin
         rd_data <= {WIDTH{1'b0}};
      end else begin
         rd_data <= mem[rd_idx];
      end
   end
endmodule // fpes_regstack

// File: dv/fpes_chk_sva.sv
// Port assertions for the error signalling core
`timescale 1ns/10ps
module fpes_chk (
   input wire       CLK_IN,
   input wire       RST_IN,
   input wire       NUMERIC_FAULT_REPORT_SEL_IN,
   input wire       IGNORE_NUMERIC_FAULT_IN_N,
   input wire       BOUNDARY_IN,
   input wire [1:0] INSTR_CLASS_IN,
   input wire       FP_EXC_IN,
   input wire       FP_ERROR_OUT_N,
   input wire       STALL_OUT,
   input wire       VEC_TAKE_OUT,
   input wire [7:0] VEC_NUM_OUT,
   input wire       PENDING_OUT
);
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (RST_IN);
   // Pending fault meets a sensitive boundary
   wire sb  = PENDING_OUT && BOUNDARY_IN && INSTR_CLASS_IN != 2'h0;
   wire ign = !IGNORE_NUMERIC_FAULT_IN_N;
   vec_take_a: assert property (sb && FP_ERROR_OUT_N && NUMERIC_FAULT_REPORT_SEL_IN
      |=> VEC_TAKE_OUT && VEC_NUM_OUT == 8'h10) else $error("vector not taken");
   err_report_a: assert property (sb && FP_ERROR_OUT_N && !NUMERIC_FAULT_REPORT_SEL_IN && !ign
      |=> !FP_ERROR_OUT_N && STALL_OUT) else $error("error not reported");
   err_hold_a: assert property (!FP_ERROR_OUT_N && !ign |=> !FP_ERROR_OUT_N)
      else $error("error output dropped early");
   stall_join_a: assert property ($fell(FP_ERROR_OUT_N) |-> STALL_OUT)
      else $error("error without stall");
   ign_clear_a: assert property (!FP_ERROR_OUT_N && ign
      |=> FP_ERROR_OUT_N && !STALL_OUT && !PENDING_OUT) else $error("ignore not honoured");
   pkd_quiet_a: assert property (!PENDING_OUT && !(FP_EXC_IN && INSTR_CLASS_IN == 2'h1)
      |=> !PENDING_OUT) else $error("pending without float fault");
   run_ign_a: assert property (PENDING_OUT && FP_ERROR_OUT_N && !BOUNDARY_IN
      |=> PENDING_OUT) else $error("pending lost outside boundary");
   vec_num_a: assert property (!VEC_TAKE_OUT |-> VEC_NUM_OUT == 8'h00)
      else $error("stray vector number");
endmodule // fpes_chk
bind fpes_core fpes_chk u_chk (.CLK_IN, .RST_IN, .NUMERIC_FAULT_REPORT_SEL_IN,
   .IGNORE_NUMERIC_FAULT_IN_N, .BOUNDARY_IN, .INSTR_CLASS_IN, .FP_EXC_IN,
   .FP_ERROR_OUT_N, .STALL_OUT, .VEC_TAKE_OUT, .VEC_NUM_OUT, .PENDING_OUT);

// File: dv/fpes_glue.sv
// Glue model: error to interrupt, port write to ignore latch
`timescale 1ns/10ps
module fpes_glue #(parameter DLY = 3) (
   input  wire clk_in,
   input  wire rst_in,
   input  wire err_in_n,
   input  wire port_wr_in,
   output reg  ign_out_n,
   output reg  ack_out
);
   reg [3:0] cnt; // Cycles since error seen
   // Interrupt path and ignore latch
   always @(posedge clk_in) begin
      if (rst_in) begin
         ign_out_n <= 1'b1;
         cnt <= 4'h0;
         ack_out <= 1'b0;
      end else begin
         cnt <= err_in_n ? 4'h0 : (cnt == DLY ? cnt : cnt + 4'h1);
         ack_out <= !err_in_n && cnt == DLY - 1;
         if (port_wr_in) ign_out_n <= 1'b0;
         else if (err_in_n) ign_out_n <= 1'b1;
      end
   end
endmodule // fpes_glue

// File: dv/testbench.sv
// Self-checking bench for the error signalling core
`timescale 1ns/10ps
module testbench;
   reg clk = 1'b0, rst = 1'b1, sel = 1'b0, bnd = 1'b0, exc = 1'b0, wr = 1'b0, pw = 1'b0;
   reg [1:0] cls = 2'h0;
   reg [2:0] wi = 3'h0, ri = 3'h0;
   reg [63:0] wd = 64'h0000;
   wire ign_n, ack, err_n, stall, take, pend;
   wire [7:0] vnum;
   wire [63:0] rd;
   integer err_total = 0, n_checks = 0;
   always #25 clk = ~clk;
   fpes_core dut (.CLK_IN(clk), .RST_IN(rst), .NUMERIC_FAULT_REPORT_SEL_IN(sel),
      .IGNORE_NUMERIC_FAULT_IN_N(ign_n), .BOUNDARY_IN(bnd), .INSTR_CLASS_IN(cls),
      .FP_EXC_IN(exc), .INT_ACK_IN(ack), .REG_WR_IN(wr), .REG_WR_IDX_IN(wi),
      .REG_WR_DATA_IN(wd), .REG_RD_IDX_IN(ri), .FP_ERROR_OUT_N(err_n), .STALL_OUT(stall),
      .VEC_TAKE_OUT(take), .VEC_NUM_OUT(vnum), .PENDING_OUT(pend), .REG_RD_DATA_OUT(rd));
   fpes_glue #(.DLY(3)) glue (.clk_in(clk), .rst_in(rst), .err_in_n(err_n),
      .port_wr_in(pw), .ign_out_n(ign_n), .ack_out(ack));
   task ck(input integer n); begin repeat (n) @(posedge clk); #1; end endtask
   task rs; begin rst = 1'b1; ck(4); rst = 1'b0; end endtask
   task chk(input [63:0] nm, input [63:0] e, input [63:0] g); begin
      n_checks = n_checks + 1;
      if (g !== e) begin
         err_total = err_total + 1;
         $display("wrong value %0s expected %h seen %h", nm, e, g);
      end
   end endtask
   task give_verdict; begin
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   end endtask
   // Float fault, then boundary of class c
   task fault(input [1:0] c); begin
      exc = 1'b1; cls = 2'h1; ck(1); exc = 1'b0;
      bnd = 1'b1; cls = c; ck(1); bnd = 1'b0; cls = 2'h0;
   end endtask
   task t_ext; integer i; begin
      rs; fault(2'h2); chk("err_n", 0, err_n); chk("stall", 1, stall);
      ck(6); chk("stall", 0, stall); chk("err_n", 0, err_n);
      pw = 1'b1; ck(1); pw = 1'b0;
      for (i = 0; i < 20 && err_n !== 1'b1; i = i + 1) ck(1);
      if (err_n !== 1'b1) begin err_total = err_total + 1; give_verdict; end
      chk("pend", 0, pend); chk("stall", 0, stall);
      $display("external report done");
   end endtask
   task t_int; begin
      rs; sel = 1'b1; fault(2'h0); chk("pend", 1, pend); chk("take", 0, take);
      bnd = 1'b1; cls = 2'h3; ck(1); bnd = 1'b0; cls = 2'h0;
      chk("take", 1, take); chk("vnum", 8'h10, vnum); chk("err_n", 1, err_n);
      ck(1); chk("take", 0, take); chk("vnum", 8'h00, vnum);
      sel = 1'b0; $display("internal vector done");
   end endtask
   task t_pkd; begin
      rs; exc = 1'b1; cls = 2'h2; ck(1); exc = 1'b0; chk("pend", 0, pend);
      fault(2'h0); pw = 1'b1; ck(1); pw = 1'b0; ck(1); chk("pend", 1, pend);
      pw = 1'b1; ck(1); pw = 1'b0; bnd = 1'b1; cls = 2'h2; ck(1); bnd = 1'b0;
      chk("pend", 0, pend); chk("err_n", 1, err_n);
      $display("packed and ignore done");
   end endtask
   task t_reg; begin
      rs; wr = 1'b1; wi = 3'h7; wd = 64'hDEAD_BEEF_0123_4567; ck(1); wr = 1'b0; ri = 3'h7;
      ck(2); chk("reg", 64'hDEAD_BEEF_0123_4567, rd);
      $display("register stack done");
   end endtask
   initial begin
      t_ext; t_int; t_pkd; t_reg;
      give_verdict;
   end
endmodule // testbench
